// [rtl/gpio_sel_map.svh]
// output source selector constants: widths, reset value, selector codes and groups
// assumes inclusion by bare name from the package and the design modules
`ifndef GPIO_SEL_MAP_SVH
`define GPIO_SEL_MAP_SVH

`define SEL_WIDTH          7
`define PIN_COUNT          4
`define SLOT_COUNT         12
`define SEL_RESET          7'h00

// lower single codes
`define CODE_LOGIC0        7'h00
`define CODE_LOGIC1        7'h01
`define CODE_IRQ_X         7'h02
`define CODE_IRQ_Y         7'h03
`define CODE_AMP1          7'h08
`define CODE_AMP2          7'h09
`define CODE_AMP3          7'h0A
`define CODE_AMP4          7'h0B
`define CODE_AMP_ANY       7'h0C
`define CODE_OSC_DIV64     7'h0F
`define CODE_TS_PATTERN    7'h10
`define CODE_SLEEP         7'h11
`define CODE_LF_OSC        7'h16
`define CODE_HF_OSC        7'h17
`define CODE_OSC_DIV32     7'h18

// slot active window codes
`define CODE_ACT_A         7'h20
`define CODE_ACT_B         7'h21
`define CODE_ACT_C         7'h22
`define CODE_ACT_GAP       7'h23
`define CODE_ACT_D         7'h24
`define CODE_ACT_E         7'h25
`define CODE_ACT_F         7'h26
`define CODE_ACT_G         7'h27
`define CODE_ACT_H         7'h28
`define CODE_ACT_I         7'h29
`define CODE_ACT_J         7'h2A
`define CODE_ACT_K         7'h2B
`define CODE_ACT_L         7'h2C

// upper three bits pick the group, low nibble the slot
`define GRP_LOW0           3'h0
`define GRP_LOW1           3'h1
`define GRP_ACTIVE         3'h2
`define GRP_LED            3'h3
`define GRP_MOD            3'h4
`define GRP_DATA           3'h5
`define GRP_FIRST_UNUSED   3'h6
`define NIBBLE_ANY         4'hF
`define SLOT_NIBBLE_LIMIT  4'hC

`endif

// [rtl/gpio_sel_pkg.sv]
// types shared by the pin output selector and its per-pin mux
// assumes the map header sits beside this file
`include "gpio_sel_map.svh"
package gpio_sel_pkg;
   typedef logic [`SEL_WIDTH-1:0]  sel_code_t;
   typedef logic [`SLOT_COUNT-1:0] slot_vec_t;
   typedef logic [`PIN_COUNT-1:0]  pin_vec_t;
endpackage

// [rtl/event_bus_if.sv]
// sequencer event bundle handed from the top to every pin mux
// assumes all members are driven on clk_i by the top
`timescale 1ns/100ps
interface event_bus_if;
   import gpio_sel_pkg::*;
   slot_vec_t   slot_active;
   slot_vec_t   led_pulse;
   slot_vec_t   mod_pulse;
   slot_vec_t   data_cycle;
   logic        irq_x;
   logic        irq_y;
   logic [3:0]  amp_en;
   logic        osc_div64;
   logic        ts_pattern;
   logic        sleep;
   logic        lf_osc;
   logic        hf_osc;
   logic        osc_div32;
   modport src (output slot_active, led_pulse, mod_pulse, data_cycle, irq_x, irq_y, amp_en,
                osc_div64, ts_pattern, sleep, lf_osc, hf_osc, osc_div32);
   modport dst (input  slot_active, led_pulse, mod_pulse, data_cycle, irq_x, irq_y, amp_en,
                osc_div64, ts_pattern, sleep, lf_osc, hf_osc, osc_div32);
endinterface

// [rtl/pin_signal_mux.sv]
// one pin: decodes its selector code onto the event bundle, registered output
// assumes events and selector are on clk_i, reset synchronous active low
`timescale 1ns/100ps
`include "gpio_sel_map.svh"
module pin_signal_mux (
   input  wire logic                  clk_i,
   input  wire logic                  reset_n_i,
   event_bus_if.dst                   ev,
   input  wire gpio_sel_pkg::sel_code_t sel_i,
   output logic                       pin_o
);
   import gpio_sel_pkg::*;

   logic pin_next;

   // pick one slot by nibble, nibbles past the last slot give low
   function automatic logic slot_bit(input slot_vec_t v, input logic [3:0] n);
      slot_bit = 1'b0;
      if (n < `SLOT_NIBBLE_LIMIT) begin
         slot_bit = v[n];
      end
   endfunction

   // slot group: single slot or all slots merged
   function automatic logic group_bit(input slot_vec_t v, input logic [3:0] n);
      if (n == `NIBBLE_ANY) begin
         group_bit = |v;
      end else begin
         group_bit = slot_bit(v, n);
      end
   endfunction

   // slot active windows, the hole at the gap code stays low
   function automatic logic active_bit(input slot_vec_t v, input sel_code_t c);
      active_bit = 1'b0;
      case (c)
         `CODE_ACT_A: active_bit = v[0];
         `CODE_ACT_B: active_bit = v[1];
         `CODE_ACT_C: active_bit = v[2];
         `CODE_ACT_D: active_bit = v[3];
         `CODE_ACT_E: active_bit = v[4];
         `CODE_ACT_F: active_bit = v[5];
         `CODE_ACT_G: active_bit = v[6];
         `CODE_ACT_H: active_bit = v[7];
         `CODE_ACT_I: active_bit = v[8];
         `CODE_ACT_J: active_bit = v[9];
         `CODE_ACT_K: active_bit = v[10];
         `CODE_ACT_L: active_bit = v[11];
         default:     active_bit = 1'b0;
      endcase
   endfunction

   // code decode, illegal groups and holes drive low
   always_comb begin
      pin_next = 1'b0;
      unique case (sel_i[6:4])
         `GRP_LOW0, `GRP_LOW1: begin
            case (sel_i)
               `CODE_LOGIC1:     pin_next = 1'b1;
               `CODE_IRQ_X:      pin_next = ev.irq_x;
               `CODE_IRQ_Y:      pin_next = ev.irq_y;
               `CODE_AMP1:       pin_next = ev.amp_en[0];
               `CODE_AMP2:       pin_next = ev.amp_en[1];
               `CODE_AMP3:       pin_next = ev.amp_en[2];
               `CODE_AMP4:       pin_next = ev.amp_en[3];
               `CODE_AMP_ANY:    pin_next = |ev.amp_en;
               `CODE_OSC_DIV64:  pin_next = ev.osc_div64;
               `CODE_TS_PATTERN: pin_next = ev.ts_pattern;
               `CODE_SLEEP:      pin_next = ev.sleep;
               `CODE_LF_OSC:     pin_next = ev.lf_osc;
               `CODE_HF_OSC:     pin_next = ev.hf_osc;
               `CODE_OSC_DIV32:  pin_next = ev.osc_div32;
               default:          pin_next = 1'b0;
            endcase
         end
         `GRP_ACTIVE: pin_next = active_bit(ev.slot_active, sel_i);
         `GRP_LED:    pin_next = group_bit(ev.led_pulse, sel_i[3:0]);
         `GRP_MOD:    pin_next = group_bit(ev.mod_pulse, sel_i[3:0]);
         `GRP_DATA:   pin_next = group_bit(ev.data_cycle, sel_i[3:0]);
         default:     pin_next = 1'b0;
      endcase
   end

   // registered pin level
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pin_o <= 1'b0;
      end else begin
         pin_o <= pin_next;
      end
   end
endmodule

// [rtl/gpio_output_signal_select.sv]
// general-purpose pin output source selectors and their registered pin drivers
// assumes every event input is made by sequencer logic on clk_i, so none is synchronised
// Function
// - a slot active code drives the pin high for exactly as long as that slot is active.
// - codes for slots A to L in order make the pin follow that slot's LED pulses.
// - the any-LED code drives the pin high whenever any slot pulses its LED.
// - codes for slots A to L in order make the pin follow that slot's modulation pulses.
// - the any-modulation code drives the pin high whenever any slot modulates.
// - codes for slots A to L in order mark each output data cycle of that slot on the pin.
// - the any-data code marks an output data cycle of any slot on the pin.
// - each pin has its own seven-bit writable selector that resets to zero.
// - every pin decodes the same code set, lower constant, interrupt and clock codes included.
// - slot active codes start with slot A at the first code and B and C right after it.
`timescale 1ns/100ps
`include "gpio_sel_map.svh"
module gpio_output_signal_select (
   input  wire logic                    clk_i,
   input  wire logic                    reset_n_i,
   input  wire gpio_sel_pkg::pin_vec_t  sel_wr_en_i,
   input  wire gpio_sel_pkg::sel_code_t sel_wr_data_i,
   input  wire gpio_sel_pkg::slot_vec_t slot_active_i,
   input  wire gpio_sel_pkg::slot_vec_t slot_led_pulse_i,
   input  wire gpio_sel_pkg::slot_vec_t slot_mod_pulse_i,
   input  wire gpio_sel_pkg::slot_vec_t slot_data_cycle_i,
   input  wire logic                    irq_x_i,
   input  wire logic                    irq_y_i,
   input  wire logic [3:0]              led_amp_en_i,
   input  wire logic                    osc_div64_i,
   input  wire logic                    ts_pattern_i,
   input  wire logic                    sleep_i,
   input  wire logic                    lf_osc_i,
   input  wire logic                    hf_osc_i,
   input  wire logic                    osc_div32_i,
   output gpio_sel_pkg::sel_code_t      per_pin_output_source_field_o [`PIN_COUNT],
   output gpio_sel_pkg::pin_vec_t       gpio_o
);
   import gpio_sel_pkg::*;

   sel_code_t   per_pin_output_source_field_reg [`PIN_COUNT];
   event_bus_if ev ();

   // selector fields, one write strobe per pin
   always_ff @(posedge clk_i) begin
      for (int k = 0; k < `PIN_COUNT; k++) begin
         if (!reset_n_i) begin
            per_pin_output_source_field_reg[k] <= `SEL_RESET;
         end else if (sel_wr_en_i[k]) begin
            per_pin_output_source_field_reg[k] <= sel_wr_data_i;
         end
      end
   end

   // selector readback
   always_comb begin
      for (int k = 0; k < `PIN_COUNT; k++) begin
         per_pin_output_source_field_o[k] = per_pin_output_source_field_reg[k];
      end
   end

   // event bundle shared by all pins
   assign ev.slot_active = slot_active_i;
   assign ev.led_pulse   = slot_led_pulse_i;
   assign ev.mod_pulse   = slot_mod_pulse_i;
   assign ev.data_cycle  = slot_data_cycle_i;
   assign ev.irq_x       = irq_x_i;
   assign ev.irq_y       = irq_y_i;
   assign ev.amp_en      = led_amp_en_i;
   assign ev.osc_div64   = osc_div64_i;
   assign ev.ts_pattern  = ts_pattern_i;
   assign ev.sleep       = sleep_i;
   assign ev.lf_osc      = lf_osc_i;
   assign ev.hf_osc      = hf_osc_i;
   assign ev.osc_div32   = osc_div32_i;

   // identical decoder on every pin
   for (genvar g = 0; g < `PIN_COUNT; g++) begin : g_pin
      pin_signal_mux u_mux (
         .clk_i     (clk_i),
         .reset_n_i (reset_n_i),
         .ev        (ev),
         .sel_i     (per_pin_output_source_field_reg[g]),
         .pin_o     (gpio_o[g])
      );
   end

   // helpers for the checks below, pin 0 and pin 1
   sel_code_t  s0;
   sel_code_t  s1;
   logic [2:0] grp0;
   logic [3:0] nib0;
   assign s0   = per_pin_output_source_field_reg[0];
   assign s1   = per_pin_output_source_field_reg[1];
   assign grp0 = s0[6:4];
   assign nib0 = s0[3:0];

   // active window follows its slot one cycle later
   property p_slot_e_active;
      @(posedge clk_i) disable iff (!reset_n_i)
      (s0 == `CODE_ACT_E) |=> (gpio_o[0] == $past(slot_active_i[4]));
   endproperty
   a_slot_e_active: assert property (p_slot_e_active)
      else $error("pin 0 does not follow slot E active");

   // whole window: three active cycles in a row give a high pin on the next cycle
   sequence s_k_window;
      (s1 == `CODE_ACT_K && slot_active_i[10]) [*3];
   endsequence
   property p_slot_k_window;
      @(posedge clk_i) disable iff (!reset_n_i)
      s_k_window |=> gpio_o[1];
   endproperty
   a_slot_k_window: assert property (p_slot_k_window)
      else $error("pin 1 dropped inside slot K window");

   // single-slot LED pulse
   property p_led_slot;
      @(posedge clk_i) disable iff (!reset_n_i)
      (grp0 == `GRP_LED && nib0 < `SLOT_NIBBLE_LIMIT) |=> (gpio_o[0] == $past(slot_led_pulse_i[nib0]));
   endproperty
   a_led_slot: assert property (p_led_slot)
      else $error("pin 0 does not follow the selected slot LED pulse");

   // any-slot LED pulse
   sequence s_any_led;
      grp0 == `GRP_LED && nib0 == `NIBBLE_ANY;
   endsequence
   property p_led_any;
      @(posedge clk_i) disable iff (!reset_n_i)
      s_any_led |=> (gpio_o[0] == $past(|slot_led_pulse_i));
   endproperty
   a_led_any: assert property (p_led_any)
      else $error("pin 0 does not merge LED pulses");

   // single-slot modulation pulse
   property p_mod_slot;
      @(posedge clk_i) disable iff (!reset_n_i)
      (grp0 == `GRP_MOD && nib0 < `SLOT_NIBBLE_LIMIT) |=> (gpio_o[0] == $past(slot_mod_pulse_i[nib0]));
   endproperty
   a_mod_slot: assert property (p_mod_slot)
      else $error("pin 0 does not follow the selected modulation pulse");

   // two merged modulation cycles give two high pin cycles
   sequence s_mod_burst;
      (grp0 == `GRP_MOD && nib0 == `NIBBLE_ANY && (|slot_mod_pulse_i)) [*2];
   endsequence
   property p_mod_any;
      @(posedge clk_i) disable iff (!reset_n_i)
      s_mod_burst |-> gpio_o[0] ##1 gpio_o[0];
   endproperty
   a_mod_any: assert property (p_mod_any)
      else $error("pin 0 missed merged modulation pulses");

   // single-slot output data cycle
   property p_data_slot;
      @(posedge clk_i) disable iff (!reset_n_i)
      (grp0 == `GRP_DATA && nib0 < `SLOT_NIBBLE_LIMIT) |=> (gpio_o[0] == $past(slot_data_cycle_i[nib0]));
   endproperty
   a_data_slot: assert property (p_data_slot)
      else $error("pin 0 does not mark the selected data cycle");

   // merged data cycles, quiet slots keep the pin low
   sequence s_data_quiet;
      grp0 == `GRP_DATA && nib0 == `NIBBLE_ANY && slot_data_cycle_i == '0;
   endsequence
   property p_data_any;
      @(posedge clk_i) disable iff (!reset_n_i)
      s_data_quiet |=> !gpio_o[0];
   endproperty
   a_data_any: assert property (p_data_any)
      else $error("pin 0 high with no data cycle in any slot");

   // reset clears the selectors of pins 0 and 1
   property p_sel_reset;
      @(posedge clk_i)
      !reset_n_i |=> (s0 == `SEL_RESET && s1 == `SEL_RESET);
   endproperty
   a_sel_reset: assert property (p_sel_reset)
      else $error("selector not cleared by reset");

   // written code is in the selector on the cycle after its write strobe
   property p_sel_write;
      @(posedge clk_i) disable iff (!reset_n_i)
      sel_wr_en_i[1] ##1 !sel_wr_en_i[1] |-> (s1 == $past(sel_wr_data_i));
   endproperty
   a_sel_write: assert property (p_sel_write)
      else $error("pin 1 selector lost its written code");

   // equal selectors give equal pins
   property p_same_decode;
      @(posedge clk_i) disable iff (!reset_n_i)
      $past(per_pin_output_source_field_reg[0] == per_pin_output_source_field_reg[2]) && $past(reset_n_i)
         |-> (gpio_o[0] == gpio_o[2]);
   endproperty
   a_same_decode: assert property (p_same_decode)
      else $error("pins 0 and 2 disagree on the same code");

   // lower interrupt code on the pin
   property p_irq_code;
      @(posedge clk_i) disable iff (!reset_n_i)
      (s1 == `CODE_IRQ_X) |=> (gpio_o[1] == $past(irq_x_i));
   endproperty
   a_irq_code: assert property (p_irq_code)
      else $error("pin 1 does not carry interrupt X");

   // slot B sits right after slot A
   property p_slot_b_code;
      @(posedge clk_i) disable iff (!reset_n_i)
      (s0 == `CODE_ACT_B) |=> (gpio_o[0] == $past(slot_active_i[1]));
   endproperty
   a_slot_b_code: assert property (p_slot_b_code)
      else $error("pin 0 does not follow slot B active");

   // gap code and unused groups stay low
   property p_undefined_low;
      @(posedge clk_i) disable iff (!reset_n_i)
      (s0 == `CODE_ACT_GAP || grp0 >= `GRP_FIRST_UNUSED) |=> !gpio_o[0];
   endproperty
   a_undefined_low: assert property (p_undefined_low)
      else $error("pin 0 high on an undefined code");

   // last slot active code
   property p_slot_l_code;
      @(posedge clk_i) disable iff (!reset_n_i)
      (s0 == `CODE_ACT_L) |=> (gpio_o[0] == $past(slot_active_i[11]));
   endproperty
   a_slot_l_code: assert property (p_slot_l_code)
      else $error("pin 0 does not follow slot L active");
endmodule

// [testbench/pin_edge_monitor.sv]
// far-side watcher of one general-purpose pin: counts rising edges seen
// assumes the pin level is settled at each rising edge of clk_i
`timescale 1ns/100ps
module pin_edge_monitor (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       pin_i,
   output logic [7:0]      rise_cnt_o
);
   logic pin_last_reg;

   // edge detect and count, cleared by reset
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pin_last_reg <= 1'b0;
         rise_cnt_o   <= 8'h00;
      end else begin
         pin_last_reg <= pin_i;
         if (pin_i && !pin_last_reg) begin
            rise_cnt_o <= rise_cnt_o + 8'h01;
         end
      end
   end
endmodule

// [testbench/gpio_output_signal_select_tb_top.sv]
// self-checking bench for the pin output source selectors
// assumes the map header and package from rtl, inputs driven on falling edges
`timescale 1ns/100ps
`include "gpio_sel_map.svh"
module gpio_output_signal_select_tb_top;
   import gpio_sel_pkg::*;
   logic        clk_i;
   logic        reset_n_i;
   pin_vec_t    sel_wr_en;
   sel_code_t   sel_wr_data;
   slot_vec_t   ev [5];              // active, led, mod, data, misc sources
   sel_code_t   field_rd [`PIN_COUNT];
   pin_vec_t    gpio;
   logic [7:0]  rise_cnt;
   logic [7:0]  cnt_start;
   int          bad_count;
   int          tests_run;
   // misc source bit b is picked by code misc_code[b]
   sel_code_t   misc_code [12] = '{7'h02, 7'h03, 7'h08, 7'h09, 7'h0A, 7'h0B,
                                   7'h0F, 7'h10, 7'h11, 7'h16, 7'h17, 7'h18};
   sel_code_t   undef_code [9] = '{7'h00, 7'h04, 7'h23, 7'h2D, 7'h3C, 7'h4C, 7'h5C, 7'h60, 7'h7F};

   gpio_output_signal_select uut (
      .clk_i                         (clk_i),
      .reset_n_i                     (reset_n_i),
      .sel_wr_en_i                   (sel_wr_en),
      .sel_wr_data_i                 (sel_wr_data),
      .slot_active_i                 (ev[0]),
      .slot_led_pulse_i              (ev[1]),
      .slot_mod_pulse_i              (ev[2]),
      .slot_data_cycle_i             (ev[3]),
      .irq_x_i                       (ev[4][0]),
      .irq_y_i                       (ev[4][1]),
      .led_amp_en_i                  (ev[4][5:2]),
      .osc_div64_i                   (ev[4][6]),
      .ts_pattern_i                  (ev[4][7]),
      .sleep_i                       (ev[4][8]),
      .lf_osc_i                      (ev[4][9]),
      .hf_osc_i                      (ev[4][10]),
      .osc_div32_i                   (ev[4][11]),
      .per_pin_output_source_field_o (field_rd),
      .gpio_o                        (gpio)
   );

   pin_edge_monitor watcher (
      .clk_i      (clk_i),
      .reset_n_i  (reset_n_i),
      .pin_i      (gpio[0]),
      .rise_cnt_o (rise_cnt)
   );

   // 25 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // one-cycle strobe, then a spare edge so the strobe is never reassigned in one step
   task automatic write_sel(input pin_vec_t pins, input sel_code_t code);
      sel_wr_en   = pins;
      sel_wr_data = code;
      @(negedge clk_i);
      sel_wr_en = 4'h0;
      @(negedge clk_i);
   endtask

   // raise one source bit for one cycle, pin must follow exactly one cycle later
   task automatic hit(input int k, input int g, input int n, input logic exp);
      ev[g] = 12'h001 << n;
      @(negedge clk_i);
      check("pin on", {7'h00, exp}, {7'h00, gpio[k]});
      ev[g] = 12'h000;
      @(negedge clk_i);
      check("pin off", 8'h00, {7'h00, gpio[k]});
   endtask

   function automatic sel_code_t act_code(input int n);
      return (n < 3) ? 7'h20 + 7'(n) : 7'h21 + 7'(n);
   endfunction

   // each slot code follows its own slot only; any-code follows every slot
   // every pin takes the code, so pin 0 sees each slot once
   task automatic test_group(input int g, input sel_code_t base);
      for (int n = 0; n < 12; n++) begin
         write_sel(4'hF, (g == 0) ? act_code(n) : base + 7'(n));
         hit(n % 4, g, n, 1'b1);
         hit(n % 4, g, (n + 1) % 12, 1'b0);
      end
      if (g != 0) begin
         write_sel(4'hF, base + 7'h0F);
         for (int n = 0; n < 12; n++) begin
            hit(n % 4, g, n, 1'b1);
         end
      end
   endtask

   // long windows: slot K held on pin 1, merged modulation from moving slots on pin 0
   task automatic test_hold;
      write_sel(4'h2, 7'h2B);
      write_sel(4'h1, 7'h4F);
      ev[0] = 12'h400;
      for (int c = 0; c < 4; c++) begin
         ev[2] = 12'h001 << (3 * c);
         @(negedge clk_i);
         check("slot K window", 8'h01, {7'h00, gpio[1]});
         check("merged modulation", 8'h01, {7'h00, gpio[0]});
      end
      ev[0] = 12'h000;
      ev[2] = 12'h000;
      @(negedge clk_i);
      check("slot K end", 8'h00, {7'h00, gpio[1]});
      check("modulation end", 8'h00, {7'h00, gpio[0]});
   endtask

   task automatic test_reset;
      for (int k = 0; k < 4; k++) begin
         check("field reset", 8'h00, {1'b0, field_rd[k]});
      end
      check("pins reset", 8'h00, {4'h0, gpio});
      write_sel(4'h5, 7'h5F);
      for (int k = 0; k < 4; k++) begin
         check("field write", (k % 2 == 0) ? 8'h5F : 8'h00, {1'b0, field_rd[k]});
      end
      write_sel(4'hF, 7'h01);
      check("pins logic one", 8'h0F, {4'h0, gpio});
      reset_n_i = 1'b0;
      @(negedge clk_i);
      check("field mid reset", 8'h00, {1'b0, field_rd[2]});
      check("pins mid reset", 8'h00, {4'h0, gpio});
      reset_n_i = 1'b1;
      @(negedge clk_i);
   endtask

   // lower single-source codes on every pin, then the any-amplifier code
   task automatic test_misc;
      for (int k = 0; k < 4; k++) begin
         for (int b = 0; b < 12; b++) begin
            write_sel(4'h1 << k, misc_code[b]);
            hit(k, 4, b, 1'b1);
            hit(k, 4, (b + 1) % 12, 1'b0);
         end
         write_sel(4'h1 << k, 7'h0C);
         for (int b = 0; b < 6; b++) begin
            hit(k, 4, b, b > 1);
         end
      end
   endtask

   // every source high, undefined codes still give a low pin
   task automatic test_undef;
      for (int g = 0; g < 5; g++) begin
         ev[g] = 12'hFFF;
      end
      for (int i = 0; i < 9; i++) begin
         write_sel(4'h1 << (i % 4), undef_code[i]);
         check("undefined code", 8'h00, {7'h00, gpio[i % 4]});
      end
      for (int g = 0; g < 5; g++) begin
         ev[g] = 12'h000;
      end
      @(negedge clk_i);
   endtask

   // main sequence
   initial begin
      bad_count   = 0;
      tests_run   = 0;
      reset_n_i   = 1'b0;
      sel_wr_en   = 4'h0;
      sel_wr_data = 7'h00;
      for (int g = 0; g < 5; g++) begin
         ev[g] = 12'h000;
      end
      repeat (8) @(negedge clk_i);
      reset_n_i = 1'b1;
      @(negedge clk_i);
      test_reset();
      cnt_start = rise_cnt;
      test_group(0, 7'h20);
      check("edges on pin 0", cnt_start + 8'h0C, rise_cnt);
      test_group(1, 7'h30);
      test_group(2, 7'h40);
      test_group(3, 7'h50);
      test_hold();
      test_misc();
      test_undef();
      stop_test();
   end

   // hang guard
   initial begin
      #4000000;
      bad_count++;
      stop_test();
   end
endmodule
